// ===== eprom_word_access.sv
/*
 eprom_word_access: register-driven read/write of the word array.
 assumes a cpu bus on the same clock: strobes one cycle, read data
 the cycle after; program supply and strap pins are asynchronous.
*/
// The plain strobed port and the placing of the registers were decided locally.
// How it works
// - a finished access clears its request bit so software can poll.
// - each finished access bumps the word pointer, stopping at 0x3f.
// - a write setting both request bits at once starts nothing.
// - after reset with high supply, port1_bit5 is undefined for 65 ms.
// - starting low-voltage programming forces global_irq_enable off.
// - on the extended variant it also forces supply_monitor off.
// - a request with word address above 0x3f is dropped.
// - a write without program supply present is dropped.
`timescale 1ns/100ps
module eprom_word_access
	import eprom_pkg::*;
#(
	parameter int      WR_CYCLES  = WR_CYC,
	parameter int      P15_CYCLES = P15_CYC,
	parameter bit      EXT_RANGE  = 1'b1
)
(
	input  wire logic              clock_in,
	input  wire logic              reset_n_in,
	input  wire logic              enable_in,
	input  wire logic [ADDR_W-1:0] addr_in,
	input  wire logic [7:0]        wdata_in,
	input  wire logic              wr_in,
	input  wire logic              rd_in,
	output logic      [7:0]        rdata_out,
	input  wire logic              program_supply_in,
	input  wire logic              port1_bit5_drive_in,
	output logic                   port1_bit5_out,
	output logic                   port1_bit5_valid_out,
	output logic                   global_irq_enable_clear_out,
	output logic                   supply_monitor_off_out,
	output logic                   irq_out
);
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_RD   = 3'b010,
		ST_WR   = 3'b100
	} fsm_t;

	typedef struct packed {
		fsm_t              fsm;
		logic [CNT_W-1:0]  cnt;
		logic [CNT_W-1:0]  p15_cnt;
		logic              p15_valid;
		logic              p15_armed;
		logic [1:0]        vpp_sync;
		logic [1:0]        warm;
		logic              rd_req;
		logic              wr_req;
		logic [7:0]        ptr;
		logic [7:0]        dh;
		logic [7:0]        dl;
		logic [1:0]        stat;
		logic [1:0]        mask;
		logic [1:0]        lvp;
		logic              gie_clr;
		logic [7:0]        rdata;
		logic              p15_q;
	} state_t;

	state_t  st_r;
	state_t  st_nxt;
	eprom_if arr ();

	logic    vpp_ok;
	logic    ptr_ok;
	logic    done_ev;
	logic    rej_ev;

	eprom_array u_array (
		.clock_in   (clock_in),
		.reset_n_in (reset_n_in),
		.enable_in  (enable_in),
		.port       (arr)
	);

	assign vpp_ok = st_r.vpp_sync[1];
	assign ptr_ok = (st_r.ptr <= {2'b00, PTR_MAX});
	assign arr.addr  = st_r.ptr[PTR_W-1:0];
	assign arr.wdata = {st_r.dh, st_r.dl};
	assign arr.wr_en = (st_r.fsm == ST_WR) && (st_r.cnt == '0);

	always_comb
	begin
		st_nxt = st_r;
		done_ev = 1'b0;
		rej_ev = 1'b0;
		st_nxt.vpp_sync = {st_r.vpp_sync[0], program_supply_in};
		st_nxt.gie_clr = 1'b0;
		st_nxt.warm = {st_r.warm[0], 1'b1};
		// strap caught once, only after the synchroniser has filled:
		// the reset zeros in it would otherwise read as no supply
		if (!st_r.p15_armed)
		begin
			if (st_r.warm[1])
			begin
				st_nxt.p15_armed = 1'b1;
				st_nxt.p15_valid = !vpp_ok;
				st_nxt.p15_cnt = CNT_W'(P15_CYCLES);
			end
		end
		else if (!st_r.p15_valid)
		begin
			if (st_r.p15_cnt <= CNT_W'(1))
				st_nxt.p15_valid = 1'b1;
			else
				st_nxt.p15_cnt = st_r.p15_cnt - CNT_W'(1);
		end
		st_nxt.p15_q = port1_bit5_drive_in;
		unique case (st_r.fsm)
			ST_IDLE:
			begin
				if (st_r.rd_req && st_r.wr_req)
					rej_ev = 1'b1;
				else if ((st_r.rd_req || st_r.wr_req) && !ptr_ok)
					rej_ev = 1'b1;
				else if (st_r.wr_req && !vpp_ok)
					rej_ev = 1'b1;
				else if (st_r.rd_req)
				begin
					st_nxt.fsm = ST_RD;
					st_nxt.cnt = CNT_W'(RD_CYC);
				end
				else if (st_r.wr_req)
				begin
					st_nxt.fsm = ST_WR;
					st_nxt.cnt = CNT_W'(WR_CYCLES);
				end
				if (rej_ev)
				begin
					// dropped request leaves no access running
					st_nxt.rd_req = 1'b0;
					st_nxt.wr_req = 1'b0;
				end
			end
			ST_RD, ST_WR:
			begin
				if (st_r.cnt == '0)
				begin
					done_ev = 1'b1;
					st_nxt.fsm = ST_IDLE;
					if (st_r.fsm == ST_RD)
					begin
						st_nxt.rd_req = 1'b0;
						st_nxt.dh = arr.rdata[15:8];
						st_nxt.dl = arr.rdata[7:0];
					end
					else
						st_nxt.wr_req = 1'b0;
					if (st_r.ptr[PTR_W-1:0] != PTR_MAX)
						st_nxt.ptr = st_r.ptr + 8'h01;
				end
				else
					st_nxt.cnt = st_r.cnt - CNT_W'(1);
			end
			default:
				st_nxt.fsm = ST_IDLE;
		endcase
		// register writes; pointer and data frozen while busy
		if (wr_in)
		begin
			unique case (addr_in)
				ADR_CTRL:
					if (st_r.fsm == ST_IDLE)
					begin
						st_nxt.rd_req = wdata_in[B_RD];
						st_nxt.wr_req = wdata_in[B_WR];
					end
				ADR_PTR:
					if (st_r.fsm == ST_IDLE)
						st_nxt.ptr = wdata_in;
				ADR_DH:
					if (st_r.fsm == ST_IDLE)
						st_nxt.dh = wdata_in;
				ADR_DL:
					if (st_r.fsm == ST_IDLE)
						st_nxt.dl = wdata_in;
				ADR_STAT:
					st_nxt.stat = st_r.stat & ~wdata_in[1:0];
				ADR_MASK:
					st_nxt.mask = wdata_in[1:0];
				ADR_LVP:
				begin
					st_nxt.lvp = wdata_in[1:0];
					if (wdata_in[L_ACT] && !st_r.lvp[L_ACT])
						st_nxt.gie_clr = 1'b1;
				end
				default:
					st_nxt.mask = st_nxt.mask;
			endcase
		end
		// set beats clear
		if (done_ev)
			st_nxt.stat[S_DONE] = 1'b1;
		if (rej_ev)
			st_nxt.stat[S_REJ] = 1'b1;
		st_nxt.rdata = 8'h00;
		if (rd_in)
		begin
			unique case (addr_in)
				ADR_CTRL:
					st_nxt.rdata = {5'h00, vpp_ok, st_r.wr_req, st_r.rd_req};
				ADR_PTR:
					st_nxt.rdata = st_r.ptr;
				ADR_DH:
					st_nxt.rdata = st_r.dh;
				ADR_DL:
					st_nxt.rdata = st_r.dl;
				ADR_STAT:
					st_nxt.rdata = {6'h00, st_r.stat};
				ADR_MASK:
					st_nxt.rdata = {6'h00, st_r.mask};
				ADR_LVP:
					st_nxt.rdata = {6'h00, st_r.lvp};
				default:
					st_nxt.rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clock_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			st_r <= '0;
			st_r.fsm <= ST_IDLE;
		end
		else if (enable_in)
			st_r <= st_nxt;
	end

	assign rdata_out = st_r.rdata;
	// one-cycle pulse, not a held level; lets the cpu core drop its enable bit
	assign global_irq_enable_clear_out = st_r.gie_clr;
	// level while low-voltage programming stays active
	assign supply_monitor_off_out =
		EXT_RANGE && st_r.lvp[L_ACT];
	// undefined window modelled as forced low, flagged invalid
	assign port1_bit5_out = st_r.p15_valid & st_r.p15_q;
	assign port1_bit5_valid_out = st_r.p15_valid;
	assign irq_out = |(st_r.stat & st_r.mask);
endmodule

// ===== eprom_pkg.sv
/*
 eprom_pkg: shared constants for the one-time-programmable word array
 access block. assumes a 20 MHz cpu clock.
*/
package eprom_pkg;
	localparam int          CLK_HZ         = 20_000_000;
	localparam int          PTR_W          = 6;
	localparam logic [5:0]  PTR_MAX        = 6'h3f;
	localparam int          WORD_W         = 16;
	localparam int          ADDR_W         = 3;
	// register map, byte-per-index
	localparam logic [2:0]  ADR_CTRL       = 3'h0;
	localparam logic [2:0]  ADR_PTR        = 3'h1;
	localparam logic [2:0]  ADR_DH         = 3'h2;
	localparam logic [2:0]  ADR_DL         = 3'h3;
	localparam logic [2:0]  ADR_STAT       = 3'h4;
	localparam logic [2:0]  ADR_MASK       = 3'h5;
	localparam logic [2:0]  ADR_LVP        = 3'h6;
	// control bit positions
	localparam int          B_RD           = 0;
	localparam int          B_WR           = 1;
	localparam int          B_VPP          = 2;
	// status bit positions
	localparam int          S_DONE         = 0;
	localparam int          S_REJ          = 1;
	// low-voltage programming bit positions
	localparam int          L_ACT          = 0;
	localparam int          L_EXT          = 1;
	// timing
	localparam int          RD_TIME_NS     = 200;
	localparam int          WR_TIME_US     = 100;
	localparam int          P15_TIME_MS    = 65;
	localparam int          RD_CYC         =
		(RD_TIME_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
	localparam int          WR_CYC         =
		WR_TIME_US * (CLK_HZ / 1_000_000);
	localparam int          P15_CYC        =
		P15_TIME_MS * (CLK_HZ / 1000);
	localparam int          CNT_W          = 21;
endpackage

// ===== eprom_if.sv
/*
 eprom_if: array port between access logic and cell array.
 assumes one clock; read data valid while busy ends.
*/
`timescale 1ns/100ps
interface eprom_if;
	import eprom_pkg::*;
	logic [PTR_W-1:0]  addr;
	logic [WORD_W-1:0] wdata;
	logic              wr_en;
	logic [WORD_W-1:0] rdata;
	modport ctrl (output addr, output wdata, output wr_en, input rdata);
	modport array (input addr, input wdata, input wr_en, output rdata);
endinterface

// ===== eprom_array.sv
/*
 eprom_array: flip-flop model of the one-time-programmable words.
 assumes erased state all ones; a write can only clear bits.
*/
`timescale 1ns/100ps
module eprom_array
	import eprom_pkg::*;
(
	input  wire logic  clock_in,
	input  wire logic  reset_n_in,
	input  wire logic  enable_in,
	eprom_if.array     port
);
	typedef struct packed {
		logic [(1<<PTR_W)-1:0][WORD_W-1:0] mem;
		logic [WORD_W-1:0]                 rd;
	} array_state_t;
	array_state_t st_r;
	array_state_t st_nxt;

	always_comb
	begin
		st_nxt = st_r;
		st_nxt.rd = st_r.mem[port.addr];
		// one-time cells: programming only clears bits
		if (port.wr_en)
			st_nxt.mem[port.addr] = st_r.mem[port.addr] & port.wdata;
	end

	always_ff @(posedge clock_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
			st_r <= '1;
		else if (enable_in)
			st_r <= st_nxt;
	end

	assign port.rdata = st_r.rd;
endmodule

// ===== eprom_access_props.sv
/* eprom_access_props: port checker for eprom_word_access.
 assumes enable_in held high and the strap sampled once per reset. */
`timescale 1ns/100ps
module eprom_access_props
	import eprom_pkg::*;
#(
	parameter int P15_CYCLES = 20,
	parameter bit EXT_RANGE  = 1'b1
)
(
	input wire logic              clock_in,
	input wire logic              reset_n_in,
	input wire logic              enable_in,
	input wire logic [ADDR_W-1:0] addr_in,
	input wire logic [7:0]        wdata_in,
	input wire logic              wr_in,
	input wire logic              rd_in,
	input wire logic [7:0]        rdata_out,
	input wire logic              program_supply_in,
	input wire logic              port1_bit5_drive_in,
	input wire logic              port1_bit5_out,
	input wire logic              port1_bit5_valid_out,
	input wire logic              global_irq_enable_clear_out,
	input wire logic              supply_monitor_off_out,
	input wire logic              irq_out
);
	int   cnt_r;
	logic sup_r;
	logic lvp_r;
	logic lvp_wr;
	logic lvp_start;
	logic rd_taken;
	assign lvp_wr = wr_in && enable_in && addr_in == ADR_LVP;
	assign lvp_start = lvp_wr && wdata_in[L_ACT] && !lvp_r;
	assign rd_taken = rd_in && enable_in;
	// saturates so a long run never wraps back into the window
	always_ff @(posedge clock_in or negedge reset_n_in)
		if (!reset_n_in)
		begin
			cnt_r <= 0;
			sup_r <= 1'b0;
			lvp_r <= 1'b0;
		end
		else
		begin
			cnt_r <= (cnt_r < 1000) ? cnt_r + 1 : cnt_r;
			sup_r <= (cnt_r == 0) ? program_supply_in : sup_r;
			// own copy of the active bit, valid on every variant
			lvp_r <= lvp_wr ? wdata_in[L_ACT] : lvp_r;
		end
	default clocking @(posedge clock_in);
	endclocking
	default disable iff (!reset_n_in);
	a_rdata_idle:
	assert property (!$past(rd_taken) |-> rdata_out == 8'h00)
		else $error("read data outside its slot");
	a_clear_one_cycle:
	assert property (global_irq_enable_clear_out |=>
		!global_irq_enable_clear_out) else $error("clear pulse too long");
	a_clear_on_start:
	assert property (lvp_start |-> ##1 global_irq_enable_clear_out)
		else $error("no clear");
	a_clear_cause:
	assert property (global_irq_enable_clear_out |-> $past(lvp_start))
		else $error("clear without start");
	a_monitor_off:
	assert property (lvp_wr |=> supply_monitor_off_out ==
		(EXT_RANGE & $past(wdata_in[L_ACT]))) else $error("monitor off");
	a_pin_masked:
	assert property (!port1_bit5_valid_out |-> !port1_bit5_out)
		else $error("pin shows level while undefined");
	a_window_low:
	assert property (sup_r && cnt_r >= 2 && cnt_r < P15_CYCLES
		|-> !port1_bit5_valid_out) else $error("window ended early");
	a_window_end:
	assert property (cnt_r >= P15_CYCLES + 4 |-> port1_bit5_valid_out)
		else $error("window never ended");
	a_pin_follows:
	assert property (port1_bit5_valid_out && $past(port1_bit5_valid_out)
		|-> port1_bit5_out == $past(port1_bit5_drive_in))
		else $error("pin does not follow drive");
	cover property (global_irq_enable_clear_out);
	cover property ($rose(port1_bit5_valid_out));
	cover property (irq_out);
endmodule

// ===== cpu_model.sv
/* cpu_model: cpu side of the register port, with bus tasks.
 assumes the block's clock and a slave that never waits. */
`timescale 1ns/100ps
module cpu_model
	import eprom_pkg::*;
(
	input  wire logic              clock_in,
	input  wire logic [7:0]        rdata_in,
	output logic      [ADDR_W-1:0] addr_out,
	output logic      [7:0]        wdata_out,
	output logic                   wr_out,
	output logic                   rd_out
);
	// one clock only: the fast oscillator is the cpu clock
	// no converter on this side, so never on around accesses
	initial
	begin
		addr_out = '0;
		wdata_out = '0;
		wr_out = 1'b0;
		rd_out = 1'b0;
	end
	// programming is one write of the request bit
	task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
		@(posedge clock_in);
		addr_out <= a;
		wdata_out <= d;
		wr_out <= 1'b1;
		@(posedge clock_in);
		wr_out <= 1'b0;
		addr_out <= ~a;
		wdata_out <= ~d;
	endtask
	task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
		@(posedge clock_in);
		addr_out <= a;
		rd_out <= 1'b1;
		@(posedge clock_in);
		rd_out <= 1'b0;
		addr_out <= ~a;
		#1 d = rdata_in;
	endtask
endmodule

// ===== tb.sv
/* tb: self-checking bench for eprom_word_access.
 assumes short counts: 8 write cycles, 20 cycle pin window. */
`timescale 1ns/100ps
module tb
	import eprom_pkg::*;
;
	logic clock_in = 1'b0;
	logic reset_n_in = 1'b0;
	logic program_supply_in = 1'b1;
	logic port1_bit5_drive_in = 1'b0;
	logic enable_in = 1'b1;
	logic [ADDR_W-1:0] addr_in;
	logic [7:0] wdata_in, rdata_out, v;
	logic wr_in, rd_in, port1_bit5_out, port1_bit5_valid_out, seen;
	logic global_irq_enable_clear_out, supply_monitor_off_out, irq_out;
	int err_total = 0;
	int n_tests = 0;
	always #25 clock_in = ~clock_in;
	eprom_word_access #(.WR_CYCLES(8), .P15_CYCLES(20)) i_dut (
		.clock_in, .reset_n_in, .enable_in, .addr_in, .wdata_in,
		.wr_in, .rd_in, .rdata_out, .program_supply_in,
		.port1_bit5_drive_in, .port1_bit5_out, .port1_bit5_valid_out,
		.global_irq_enable_clear_out, .supply_monitor_off_out, .irq_out);
	cpu_model i_cpu (.clock_in, .rdata_in(rdata_out), .addr_out(addr_in),
		.wdata_out(wdata_in), .wr_out(wr_in), .rd_out(rd_in));
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			err_total++;
			$display("[FAIL] %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic rchk(input logic [2:0] a, input logic [7:0] e);
		i_cpu.rd_reg(a, v);
		chk(v, e);
	endtask
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		i_cpu.wr_reg(a, d);
	endtask
	// bounded poll: a stuck request bit fails instead of hanging
	task automatic go(input logic [7:0] req);
		wr(ADR_CTRL, req);
		for (int i = 0; i < 40; i++)
		begin
			i_cpu.rd_reg(ADR_CTRL, v);
			if (v[1:0] === 2'b00)
				return;
		end
		chk({6'h00, v[1:0]}, 8'h00);
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic t_window();
		repeat (5) @(posedge clock_in);
		#1 chk({7'h00, port1_bit5_valid_out}, 8'h00);
		repeat (25) @(posedge clock_in);
		port1_bit5_drive_in <= 1'b1;
		repeat (2) @(posedge clock_in);
		#1 chk({7'h00, port1_bit5_out}, 8'h01);
		chk({7'h00, port1_bit5_valid_out}, 8'h01);
		$display("window test done");
	endtask
	task automatic t_access();
		wr(ADR_PTR, 8'h05);
		go(8'h01);
		rchk(ADR_CTRL, 8'h04);
		rchk(ADR_DH, 8'hff);
		rchk(ADR_DL, 8'hff);
		rchk(ADR_PTR, 8'h06);
		wr(ADR_PTR, 8'h3f);
		wr(ADR_DH, 8'h12);
		wr(ADR_DL, 8'h34);
		go(8'h02);
		rchk(ADR_PTR, 8'h3f);
		// wipe the data bytes so only the read can bring the word back
		wr(ADR_DH, 8'h00);
		wr(ADR_DL, 8'h00);
		go(8'h01);
		rchk(ADR_DH, 8'h12);
		rchk(ADR_DL, 8'h34);
		rchk(ADR_PTR, 8'h3f);
		$display("access test done");
	endtask
	task automatic t_reject();
		wr(ADR_STAT, 8'h03);
		wr(ADR_PTR, 8'h10);
		go(8'h03);
		rchk(ADR_PTR, 8'h10);
		rchk(ADR_STAT, 8'h02);
		#1 chk({7'h00, irq_out}, 8'h00);
		wr(ADR_MASK, 8'h02);
		#1 chk({7'h00, irq_out}, 8'h01);
		wr(ADR_STAT, 8'h02);
		#1 chk({7'h00, irq_out}, 8'h00);
		wr(ADR_PTR, 8'h40);
		go(8'h01);
		rchk(ADR_PTR, 8'h40);
		rchk(ADR_STAT, 8'h02);
		rchk(3'h7, 8'h00);
		program_supply_in <= 1'b0;
		wr(ADR_PTR, 8'h01);
		wr(ADR_DH, 8'h00);
		go(8'h02);
		rchk(ADR_PTR, 8'h01);
		go(8'h01);
		rchk(ADR_DH, 8'hff);
		$display("reject test done");
	endtask
	task automatic t_lvp();
		wr(ADR_LVP, 8'h01);
		seen = 1'b0;
		repeat (3)
		begin
			#1 seen |= global_irq_enable_clear_out;
			@(posedge clock_in);
		end
		chk({7'h00, seen}, 8'h01);
		chk({7'h00, supply_monitor_off_out}, 8'h01);
		wr(ADR_LVP, 8'h00);
		#1 chk({7'h00, supply_monitor_off_out}, 8'h00);
		// clock enable low: a write in that window must not land
		enable_in <= 1'b0;
		wr(ADR_MASK, 8'h01);
		enable_in <= 1'b1;
		rchk(ADR_MASK, 8'h02);
		$display("lvp test done");
	endtask
	initial
	begin
		repeat (5000) @(posedge clock_in);
		err_total++;
		stop_test();
	end
	initial
	begin
		repeat (20) @(posedge clock_in);
		reset_n_in <= 1'b1;
		t_window();
		t_access();
		t_reject();
		t_lvp();
		stop_test();
	end
endmodule
bind eprom_word_access eprom_access_props #(.P15_CYCLES(P15_CYCLES),
	.EXT_RANGE(EXT_RANGE)) i_props (.clock_in, .reset_n_in, .enable_in,
	.addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out, .program_supply_in,
	.port1_bit5_drive_in, .port1_bit5_out, .port1_bit5_valid_out,
	.global_irq_enable_clear_out, .supply_monitor_off_out, .irq_out);
